// file: rtl/esfp_pkg.sv
// esfp_pkg: constants and field carriers for the extended squitter field packer
// assumes bit 1 of a 56-bit payload is its most significant bit
package esfp_pkg;
  localparam int ME_W = 56;
  localparam int CAP_W = 3;
  localparam int CHAR_W = 6;
  localparam int NUM_CHARS = 8;
  // message kinds, gray coded
  typedef enum logic [1:0] {
    ESFP_MSG_AIR_POS = 2'h0,
    ESFP_MSG_SURF_POS = 2'h1,
    ESFP_MSG_IDENT = 2'h3,
    ESFP_MSG_VEL = 2'h2
  } esfp_msg_e;
  // surveillance status codes
  localparam logic [1:0] SURV_NONE = 2'h0;
  localparam logic [1:0] SURV_EMERG = 2'h1;
  localparam logic [1:0] SURV_MODEA_CHG = 2'h2;
  localparam logic [1:0] SURV_IDENT = 2'h3;
  // velocity subtype codes
  localparam logic [2:0] VEL_NORMAL = 3'h0;
  localparam logic [2:0] VEL_SUPERSONIC = 3'h1;
  // reset values
  localparam logic [CAP_W-1:0] CAP_RST = 3'h0;
  localparam logic [55:0] ME_RST = 56'h0;
  // field msb positions, 1-based from the payload msb
  localparam int POS_SURV = 6;
  localparam int POS_INTEG = 8;
  localparam int POS_ALT = 9;
  localparam int POS_TIME = 21;
  localparam int POS_CPRF = 22;
  localparam int POS_LAT = 23;
  localparam int POS_LON = 40;
  localparam int POS_MOVE = 6;
  localparam int POS_TRK_ST = 13;
  localparam int POS_TRK = 14;
  localparam int POS_CAT = 6;
  localparam int POS_CHARS = 9;
  localparam int POS_VSUB = 6;
  localparam int POS_INTENT = 9;
  localparam int POS_NACV = 11;
  localparam int POS_EW_DIR = 14;
  localparam int POS_EW = 15;
  localparam int POS_NS_DIR = 25;
  localparam int POS_NS = 26;
  localparam int POS_VR_SRC = 36;
  localparam int POS_VR_SGN = 37;
  localparam int POS_VR = 38;
  localparam int POS_BARO_SGN = 49;
  localparam int POS_BARO = 50;

  typedef struct packed {
    logic [1:0] surv_status;
    logic integ_supp;
    logic [11:0] altitude;
    logic time_coupled;
    logic cpr_odd;
    logic [16:0] lat;
    logic [16:0] lon;
  } esfp_air_pos_s;

  typedef struct packed {
    logic [6:0] movement;
    logic track_valid;
    logic [6:0] track;
    logic time_coupled;
    logic cpr_odd;
    logic [16:0] lat;
    logic [16:0] lon;
  } esfp_surf_pos_s;

  typedef struct packed {
    logic [2:0] category;
    logic [47:0] chars;
  } esfp_ident_s;

  typedef struct packed {
    logic supersonic;
    logic intent_valid;
    logic intent_change;
    logic [2:0] nacv;
    logic ew_dir;
    logic [9:0] ew_speed;
    logic ns_dir;
    logic [9:0] ns_speed;
    logic vr_source;
    logic vr_sign;
    logic [8:0] vr;
    logic baro_valid;
    logic baro_sign;
    logic [6:0] baro_diff;
  } esfp_vel_s;
endpackage

// file: rtl/esfp_field_ins.sv
// esfp_field_ins: places one field into a 56-bit payload word
// assumes the field fits inside the word at its 1-based msb position
`timescale 1ns/10ps
module esfp_field_ins
  import esfp_pkg::*;
#(
  parameter int POS = 1,
  parameter int W = 1
) (
  input wire logic [ME_W-1:0] word_in,
  input wire logic [W-1:0] field_in,
  output logic [ME_W-1:0] word_out
);
  // payload bit n sits at vector index ME_W-n
  localparam int LSB = ME_W - POS - W + 1;
  always_comb begin
    word_out = word_in;
    word_out[LSB +: W] = field_in;
  end
endmodule

// file: rtl/esfp_char_pack.sv
// esfp_char_pack: packs identification characters into 6-bit cells
// assumes characters arrive already encoded, first character in the top cell
`timescale 1ns/10ps
module esfp_char_pack
  import esfp_pkg::*;
#(
  parameter int N = NUM_CHARS
) (
  input wire logic [N*8-1:0] chars_in,
  output logic [N*CHAR_W-1:0] cells_out
);
  // only the low six bits of each byte carry the character code
  genvar i;
  for (i = 0; i < N; i++) begin : g_char
    assign cells_out[i*CHAR_W +: CHAR_W] = chars_in[i*8 +: CHAR_W];
  end
endmodule

// file: rtl/esfp_packer.sv
// esfp_packer: builds capability code and ME payload of one extended squitter
// assumes sources hold their fields steady while load_in is high
`timescale 1ns/10ps
module esfp_packer
  import esfp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire esfp_msg_e msg_kind_in,
  input wire logic [CAP_W-1:0] capability_in,
  input wire logic source_approved_in,
  input wire esfp_air_pos_s air_pos_in,
  input wire esfp_surf_pos_s surf_pos_in,
  input wire logic [2:0] ident_category_in,
  input wire logic [63:0] ident_chars_in,
  input wire esfp_vel_s vel_in,
  output logic frame_valid_out,
  output logic refused_out,
  output esfp_msg_e msg_kind_out,
  output logic [CAP_W-1:0] transponder_capability_code_out,
  output logic [ME_W-1:0] me_out
);
  logic [ME_W-1:0] a0;
  logic [ME_W-1:0] a1;
  logic [ME_W-1:0] a2;
  logic [ME_W-1:0] a3;
  logic [ME_W-1:0] a4;
  logic [ME_W-1:0] a5;
  logic [ME_W-1:0] a6;
  logic [ME_W-1:0] a7;
  logic [ME_W-1:0] s0;
  logic [ME_W-1:0] s1;
  logic [ME_W-1:0] s2;
  logic [ME_W-1:0] s3;
  logic [ME_W-1:0] s4;
  logic [ME_W-1:0] s5;
  logic [ME_W-1:0] s6;
  logic [ME_W-1:0] i0;
  logic [ME_W-1:0] i1;
  logic [ME_W-1:0] v0;
  logic [ME_W-1:0] v1;
  logic [ME_W-1:0] v2;
  logic [ME_W-1:0] v3;
  logic [ME_W-1:0] v4;
  logic [ME_W-1:0] v5;
  logic [ME_W-1:0] v6;
  logic [ME_W-1:0] v7;
  logic [ME_W-1:0] v8;
  logic [ME_W-1:0] v9;
  logic [ME_W-1:0] v10;
  logic [ME_W-1:0] v11;
  logic [ME_W-1:0] v12;
  logic [NUM_CHARS*CHAR_W-1:0] cells;
  logic [2:0] vel_subtype;
  logic intent_bit;
  logic [7:0] baro_field;
  logic [ME_W-1:0] next_me;

  // airborne position
  esfp_field_ins #(
    .POS(POS_SURV),
    .W(2)
  ) u_a0 (
    .word_in(ME_RST),
    .field_in(air_pos_in.surv_status),
    .word_out(a0)
  );
  esfp_field_ins #(
    .POS(POS_INTEG),
    .W(1)
  ) u_a1 (
    .word_in(a0),
    .field_in(air_pos_in.integ_supp),
    .word_out(a1)
  );
  esfp_field_ins #(
    .POS(POS_ALT),
    .W(12)
  ) u_a2 (
    .word_in(a1),
    .field_in(air_pos_in.altitude),
    .word_out(a2)
  );
  esfp_field_ins #(
    .POS(POS_TIME),
    .W(1)
  ) u_a3 (
    .word_in(a2),
    .field_in(air_pos_in.time_coupled),
    .word_out(a3)
  );
  esfp_field_ins #(
    .POS(POS_CPRF),
    .W(1)
  ) u_a4 (
    .word_in(a3),
    .field_in(air_pos_in.cpr_odd),
    .word_out(a4)
  );
  esfp_field_ins #(
    .POS(POS_LAT),
    .W(17)
  ) u_a5 (
    .word_in(a4),
    .field_in(air_pos_in.lat),
    .word_out(a5)
  );
  esfp_field_ins #(
    .POS(POS_LON),
    .W(17)
  ) u_a6 (
    .word_in(a5),
    .field_in(air_pos_in.lon),
    .word_out(a6)
  );
  assign a7 = a6;

  // surface position
  esfp_field_ins #(
    .POS(POS_MOVE),
    .W(7)
  ) u_s0 (
    .word_in(ME_RST),
    .field_in(surf_pos_in.movement),
    .word_out(s0)
  );
  esfp_field_ins #(
    .POS(POS_TRK_ST),
    .W(1)
  ) u_s1 (
    .word_in(s0),
    .field_in(surf_pos_in.track_valid),
    .word_out(s1)
  );
  esfp_field_ins #(
    .POS(POS_TRK),
    .W(7)
  ) u_s2 (
    .word_in(s1),
    .field_in(surf_pos_in.track),
    .word_out(s2)
  );
  esfp_field_ins #(
    .POS(POS_TIME),
    .W(1)
  ) u_s3 (
    .word_in(s2),
    .field_in(surf_pos_in.time_coupled),
    .word_out(s3)
  );
  esfp_field_ins #(
    .POS(POS_CPRF),
    .W(1)
  ) u_s4 (
    .word_in(s3),
    .field_in(surf_pos_in.cpr_odd),
    .word_out(s4)
  );
  esfp_field_ins #(
    .POS(POS_LAT),
    .W(17)
  ) u_s5 (
    .word_in(s4),
    .field_in(surf_pos_in.lat),
    .word_out(s5)
  );
  esfp_field_ins #(
    .POS(POS_LON),
    .W(17)
  ) u_s6 (
    .word_in(s5),
    .field_in(surf_pos_in.lon),
    .word_out(s6)
  );

  // identification and category
  esfp_char_pack #(
    .N(NUM_CHARS)
  ) u_chars (
    .chars_in(ident_chars_in),
    .cells_out(cells)
  );
  esfp_field_ins #(
    .POS(POS_CAT),
    .W(3)
  ) u_i0 (
    .word_in(ME_RST),
    .field_in(ident_category_in),
    .word_out(i0)
  );
  esfp_field_ins #(
    .POS(POS_CHARS),
    .W(NUM_CHARS*CHAR_W)
  ) u_i1 (
    .word_in(i0),
    .field_in(cells),
    .word_out(i1)
  );

  // velocity over ground
  assign vel_subtype = vel_in.supersonic ? VEL_SUPERSONIC : VEL_NORMAL;
  // optional flag only sent when its source vouches for it
  assign intent_bit = vel_in.intent_valid & vel_in.intent_change;
  // conditional field: zero when no difference is available
  assign baro_field = vel_in.baro_valid ? {vel_in.baro_sign, vel_in.baro_diff}
                                        : 8'h00;
  esfp_field_ins #(
    .POS(POS_VSUB),
    .W(3)
  ) u_v0 (
    .word_in(ME_RST),
    .field_in(vel_subtype),
    .word_out(v0)
  );
  esfp_field_ins #(
    .POS(POS_INTENT),
    .W(1)
  ) u_v1 (
    .word_in(v0),
    .field_in(intent_bit),
    .word_out(v1)
  );
  esfp_field_ins #(
    .POS(POS_NACV),
    .W(3)
  ) u_v2 (
    .word_in(v1),
    .field_in(vel_in.nacv),
    .word_out(v2)
  );
  esfp_field_ins #(
    .POS(POS_EW_DIR),
    .W(1)
  ) u_v3 (
    .word_in(v2),
    .field_in(vel_in.ew_dir),
    .word_out(v3)
  );
  esfp_field_ins #(
    .POS(POS_EW),
    .W(10)
  ) u_v4 (
    .word_in(v3),
    .field_in(vel_in.ew_speed),
    .word_out(v4)
  );
  esfp_field_ins #(
    .POS(POS_NS_DIR),
    .W(1)
  ) u_v5 (
    .word_in(v4),
    .field_in(vel_in.ns_dir),
    .word_out(v5)
  );
  esfp_field_ins #(
    .POS(POS_NS),
    .W(10)
  ) u_v6 (
    .word_in(v5),
    .field_in(vel_in.ns_speed),
    .word_out(v6)
  );
  esfp_field_ins #(
    .POS(POS_VR_SRC),
    .W(1)
  ) u_v7 (
    .word_in(v6),
    .field_in(vel_in.vr_source),
    .word_out(v7)
  );
  esfp_field_ins #(
    .POS(POS_VR_SGN),
    .W(1)
  ) u_v8 (
    .word_in(v7),
    .field_in(vel_in.vr_sign),
    .word_out(v8)
  );
  esfp_field_ins #(
    .POS(POS_VR),
    .W(9)
  ) u_v9 (
    .word_in(v8),
    .field_in(vel_in.vr),
    .word_out(v9)
  );
  esfp_field_ins #(
    .POS(POS_BARO_SGN),
    .W(8)
  ) u_v10 (
    .word_in(v9),
    .field_in(baro_field),
    .word_out(v10)
  );
  assign v11 = v10;
  assign v12 = v11;

  // bits not written above stay at the zero seed word
  always_comb begin
    case (msg_kind_in)
      ESFP_MSG_AIR_POS: next_me = a7;
      ESFP_MSG_SURF_POS: next_me = s6;
      ESFP_MSG_IDENT: next_me = i1;
      ESFP_MSG_VEL: next_me = v12;
      default: next_me = ME_RST;
    endcase
  end

  // unapproved data is never sent; a default payload would mislead receivers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      frame_valid_out <= 1'b0;
      refused_out <= 1'b0;
    end else begin
      frame_valid_out <= load_in & source_approved_in;
      refused_out <= load_in & ~source_approved_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      me_out <= ME_RST;
      msg_kind_out <= ESFP_MSG_AIR_POS;
      transponder_capability_code_out <= CAP_RST;
    end else if (load_in && source_approved_in) begin
      me_out <= next_me;
      msg_kind_out <= msg_kind_in;
      transponder_capability_code_out <= capability_in;
    end
  end
endmodule

// file: sim/esfp_src_model.sv
// esfp_src_model: avionics source stand-in giving approved field patterns
// assumes pat_in and surv_in are held steady around each request
`timescale 1ns/10ps
module esfp_src_model
  import esfp_pkg::*;
(
  input wire logic [1:0] pat_in,
  input wire logic [1:0] surv_in,
  output logic [2:0] cap_out,
  output esfp_air_pos_s air_out,
  output esfp_surf_pos_s surf_out,
  output logic [2:0] cat_out,
  output logic [63:0] chars_out,
  output esfp_vel_s vel_out
);
  localparam logic [63:0] SEED = 64'h96E1_6C3A_5B27_D48F;
  logic [63:0] w;
  // four distinct non-zero patterns, so a stuck field cannot pass
  assign w = (pat_in[1] ? {SEED[31:0], SEED[63:32]} : SEED) ^ {64{pat_in[0]}};
  assign cap_out = w[5:3];
  assign air_out = {surv_in, w[48:0]};
  assign surf_out = w[63:13];
  assign cat_out = w[2:0];
  assign chars_out = w;
  assign vel_out = w[55:8];
endmodule

// file: sim/esfp_packer_sva.sv
// esfp_packer_sva: port-level checks of the packed frame fields
// assumes one clock and a sync reset; bound from the testbench
`timescale 1ns/10ps
module esfp_packer_sva
  import esfp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire esfp_msg_e msg_kind_in,
  input wire logic [CAP_W-1:0] capability_in,
  input wire logic source_approved_in,
  input wire esfp_air_pos_s air_pos_in,
  input wire esfp_surf_pos_s surf_pos_in,
  input wire logic [2:0] ident_category_in,
  input wire logic [63:0] ident_chars_in,
  input wire esfp_vel_s vel_in,
  input wire logic frame_valid_out,
  input wire logic refused_out,
  input wire esfp_msg_e msg_kind_out,
  input wire logic [CAP_W-1:0] transponder_capability_code_out,
  input wire logic [ME_W-1:0] me_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic acc;
  assign acc = load_in & source_approved_in;
  a_cap_code: assert property (acc |=> frame_valid_out && !refused_out
    && transponder_capability_code_out == $past(capability_in)
    && msg_kind_out == $past(msg_kind_in)) else $error("capability wrong");
  a_refuse_hold: assert property (load_in && !source_approved_in |=> refused_out
    && !frame_valid_out && $stable(me_out)) else $error("refusal wrong");
  a_air_fields: assert property (acc && msg_kind_in == ESFP_MSG_AIR_POS |=>
    me_out == {5'h0, $past(air_pos_in)}) else $error("air payload wrong");
  a_surf_fields: assert property (acc && msg_kind_in == ESFP_MSG_SURF_POS |=>
    me_out == {5'h0, $past(surf_pos_in)}) else $error("surface payload wrong");
  a_ident_cat: assert property (acc && msg_kind_in == ESFP_MSG_IDENT |=>
    me_out[55:48] == {5'h0, $past(ident_category_in)}) else $error("category wrong");
  a_vel_subtype: assert property (acc && msg_kind_in == ESFP_MSG_VEL |=>
    me_out[50:48] == {2'h0, $past(vel_in.supersonic)}) else $error("subtype wrong");
  a_vel_nacv: assert property (acc && msg_kind_in == ESFP_MSG_VEL |=>
    me_out[45:43] == $past(vel_in.nacv)) else $error("accuracy wrong");
  a_vel_speed: assert property (acc && msg_kind_in == ESFP_MSG_VEL |=>
    me_out[42:21] == $past(vel_in[41:20])) else $error("speed wrong");
  a_vel_reserved: assert property (acc && msg_kind_in == ESFP_MSG_VEL |=>
    me_out[55:51] == 5'h0 && !me_out[46] && me_out[9:8] == 2'h0)
    else $error("reserved bits set");
  a_vel_rate: assert property (acc && msg_kind_in == ESFP_MSG_VEL |=>
    me_out[20:10] == $past(vel_in[19:9])) else $error("vertical rate wrong");
  c_air: cover property (acc && msg_kind_in == ESFP_MSG_AIR_POS);
  c_vel: cover property (acc && msg_kind_in == ESFP_MSG_VEL);
  c_refuse: cover property (acc ##1 load_in && !source_approved_in);
endmodule

// file: sim/esfp_packer_tb.sv
// esfp_packer_tb: directed scenarios for the squitter field packer
// assumes the source model feeds all data ports; checker bound at foot
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module esfp_packer_tb;
  import esfp_pkg::*;
  logic clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic load_in = 1'h0;
  logic source_approved_in = 1'h1;
  esfp_msg_e msg_kind_in = ESFP_MSG_AIR_POS;
  logic [1:0] pat = 2'h0;
  logic [1:0] surv = 2'h0;
  logic [2:0] cap, cat, cap_o;
  logic [63:0] chars;
  esfp_air_pos_s air;
  esfp_surf_pos_s surf;
  esfp_vel_s vel;
  logic fv, rf;
  esfp_msg_e kind_o;
  logic [55:0] me, held;
  int n_errors = 0;
  int compares = 0;
  always #50 clk_in = ~clk_in;
  esfp_src_model i_esfp_src_model (.pat_in(pat), .surv_in(surv), .cap_out(cap),
    .air_out(air), .surf_out(surf), .cat_out(cat), .chars_out(chars), .vel_out(vel));
  esfp_packer i_esfp_packer (.clk_in(clk_in), .reset_in(reset_in), .load_in(load_in),
    .msg_kind_in(msg_kind_in), .capability_in(cap), .source_approved_in(source_approved_in),
    .air_pos_in(air), .surf_pos_in(surf), .ident_category_in(cat), .ident_chars_in(chars),
    .vel_in(vel), .frame_valid_out(fv), .refused_out(rf), .msg_kind_out(kind_o),
    .transponder_capability_code_out(cap_o), .me_out(me));
  function automatic logic [55:0] ident_exp(input logic [2:0] c, input logic [63:0] ch);
    logic [47:0] cells;
    for (int j = 0; j < 8; j++) cells[47-6*j -: 6] = ch[8*(7-j) +: 6];
    return {5'h0, c, cells};
  endfunction
  // absent baro data reads as a zeroed field, intent flag needs both bits
  function automatic logic [55:0] vel_exp(input esfp_vel_s v);
    return {7'h0, v.supersonic, v.intent_valid & v.intent_change, 1'h0, v.nacv, v.ew_dir,
      v.ew_speed, v.ns_dir, v.ns_speed, v.vr_source, v.vr_sign, v.vr, 2'h0,
      v.baro_valid & v.baro_sign, v.baro_valid ? v.baro_diff : 7'h0};
  endfunction
  // raise a request now, judge the pulse at the next falling edge, after the rising edge that registers it
  task automatic req(input esfp_msg_e k, input logic ap);
    load_in = 1'h1;
    msg_kind_in = k;
    source_approved_in = ap;
    @(negedge clk_in);
    `CHK("valid", ap, fv)
    `CHK("refused", ~ap, rf)
    if (ap) `CHK("cap", cap, cap_o)
    if (ap) `CHK("kind", k, kind_o)
  endtask
  task automatic idle;
    load_in = 1'h0;
    @(negedge clk_in);
    `CHK("quiet", 2'h0, {fv, rf})
  endtask
  task automatic t_air;
    for (int i = 0; i < 4; i++) begin
      pat = 2'(i);
      surv = 2'(i);
      req(ESFP_MSG_AIR_POS, 1'h1);
      `CHK("air", {5'h0, air}, me)
    end
    idle();
  endtask
  task automatic t_surf;
    for (int i = 2; i < 4; i++) begin
      pat = 2'(i);
      req(ESFP_MSG_SURF_POS, 1'h1);
      `CHK("surf", {5'h0, surf}, me)
    end
    idle();
  endtask
  task automatic t_ident;
    for (int i = 0; i < 2; i++) begin
      pat = 2'(i);
      req(ESFP_MSG_IDENT, 1'h1);
      `CHK("ident", ident_exp(cat, chars), me)
    end
    idle();
  endtask
  task automatic t_vel;
    for (int i = 0; i < 4; i++) begin
      pat = 2'(i);
      req(ESFP_MSG_VEL, 1'h1);
      `CHK("vel", vel_exp(vel), me)
    end
    idle();
  endtask
  // refusal straight after an accept must leave the frame untouched
  task automatic t_refuse;
    pat = 2'h0;
    req(ESFP_MSG_VEL, 1'h1);
    held = vel_exp(vel);
    pat = 2'h1;
    req(ESFP_MSG_IDENT, 1'h0);
    `CHK("held", held, me)
    `CHK("kind", ESFP_MSG_VEL, kind_o)
    idle();
  endtask
  // reset must clear every output, also when it strikes mid-run
  task automatic t_reset(input int n);
    reset_in = 1'h1;
    repeat (n) @(negedge clk_in);
    `CHK("rst me", ME_RST, me)
    `CHK("rst cap", CAP_RST, cap_o)
    `CHK("rst kind", ESFP_MSG_AIR_POS, kind_o)
    `CHK("rst pulses", 2'h0, {fv, rf})
    reset_in = 1'h0;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_reset(16);
    t_air();
    t_surf();
    t_ident();
    t_vel();
    t_reset(2);
    t_refuse();
    complete_run();
  end
endmodule
bind esfp_packer esfp_packer_sva i_esfp_packer_sva (.clk_in(clk_in), .reset_in(reset_in),
  .load_in(load_in), .msg_kind_in(msg_kind_in), .capability_in(capability_in),
  .source_approved_in(source_approved_in), .air_pos_in(air_pos_in),
  .surf_pos_in(surf_pos_in), .ident_category_in(ident_category_in),
  .ident_chars_in(ident_chars_in), .vel_in(vel_in), .frame_valid_out(frame_valid_out),
  .refused_out(refused_out), .msg_kind_out(msg_kind_out),
  .transponder_capability_code_out(transponder_capability_code_out), .me_out(me_out));
